// file: rtl/pnp_cfg_regs.svh
// configuration index map, field positions, reset values and limits
`ifndef PNP_CFG_REGS_SVH
`define PNP_CFG_REGS_SVH
`define NUM_UNITS 15
`define WAKE_UNIT 4'h4
`define KBD_UNIT 4'h6
`define IDX_UNIT_NUM 8'h07
`define IDX_CHIP_ID 8'h20
`define IDX_GCFG_ONE 8'h21
`define IDX_GCFG_THREE 8'h23
`define IDX_ACTIVATE 8'h30
`define IDX_BASE0_HI 8'h60
`define IDX_BASE0_LO 8'h61
`define IDX_BASE1_HI 8'h62
`define IDX_BASE1_LO 8'h63
`define IDX_IRQ_NUM 8'h70
`define IDX_IRQ_TYPE 8'h71
`define IDX_DMA_FIRST 8'h74
`define IDX_DMA_SECOND 8'h75
`define IDX_FUNC_CFG 8'hF0
`define IDX_UNIT_FIRST 8'h30
`define CFG_PORT_LOW 16'h002E
`define CFG_PORT_HIGH 16'h004E
`define GC1_SWRST_BIT 1
`define GC1_LOCK_BIT 7
`define ACT_ENABLE_BIT 0
`define IRQ_WAKE_BIT 4
`define DMA_NONE 3'h4
`define RD_UNIMPL 8'h00
`define RD_UNIMPL_DMA 8'h04
`define PAR_BASE_MAX 16'h03F8
`define LEGACY_BASE_MASK 16'h07FF
`define FULL_BASE_MASK 16'hFFFF
// identification value is arbitrary
`define CHIP_ID_VALUE 8'h5A
`define FLOPPY_BASE_RST 16'h03F0
`define PAR_BASE_RST 16'h0278
`define SER2_BASE_RST 16'h02F8
`define SER1_BASE_RST 16'h03F8
`define KBD_DATA_RST 16'h0060
`define KBD_CMD_RST 16'h0064
`define FLOPPY_IRQ_RST 5'h06
`define PAR_IRQ_RST 5'h05
`define SER2_IRQ_RST 5'h03
`define SER1_IRQ_RST 5'h04
`define MOUSE_IRQ_RST 5'h0C
`define KBD_IRQ_RST 5'h01
`define FLOPPY_DMA_RST 3'h2
`endif

// file: rtl/pnp_cfg_pkg.sv
// types shared by the configuration register file
package pnp_cfg_pkg;
    typedef enum logic [3:0] {
        UNIT_FLOPPY, UNIT_PARALLEL, UNIT_SERIAL2, UNIT_SERIAL1, UNIT_WAKE,
        UNIT_MOUSE, UNIT_KBD, UNIT_GPIO, UNIT_BUS2W, UNIT_FAN, UNIT_TIMER,
        UNIT_GAME, UNIT_MIDI, UNIT_VOLT, UNIT_TEMP
    } unit_t;
    typedef logic [15:0] io_addr_t;
endpackage

// file: rtl/pnp_base_decode.sv
// full 16-bit range match of a request address against one base descriptor
`timescale 1ns/1ps
module pnp_base_decode (
    input wire pnp_cfg_pkg::io_addr_t reqAddr,
    input wire pnp_cfg_pkg::io_addr_t base,
    input wire logic [2:0] alignBits,
    input wire logic enable,
    output logic hit
);
    pnp_cfg_pkg::io_addr_t keepMask;
    assign keepMask = 16'hFFFF << alignBits;
    assign hit = enable && ((reqAddr & keepMask) == base);
endmodule

// file: rtl/pnp_config_and_address_decode.sv
// plug-and-play configuration register file with per-unit I/O decoding
//
// Behaviour
// RL1: first/second DMA select bits 2-0 pick channel 0-3.
// RL2: DMA select value 4 means no channel; 5-7 are reserved.
// RL3: activate bit 0 enables the unit's registers and resources.
// RL4: descriptor 0 at 60h-61h holds the primary 16-bit base.
// RL5: descriptor 1 at 62h-63h exists only for multi-range units.
// RL6: indexes 70h and 71h assign and type the unit's interrupt.
// RL7: indexes from F0h hold function-specific controls.
// RL8: global config one bit 1 triggers a software reset.
// RL9: software reset leaves write-locked bits unchanged.
// RL10: hardware reset clears all but wake unit and retained bits.
// RL11: retention power-up reset clears every retained register.
// RL12: standby power-up resets the wake unit except retained bits.
// RL13: after hardware reset the config port is 2Eh or 4Eh per strap.
// RL14: after hardware reset only the keyboard unit is active; the code leaves the wake unit's activate bit as it was.
// RL15: pin selects in global config three bits 1-0 take defaults.
// RL16: legacy units get legacy resources; others get base 00h.
// RL17: all 16 address bits are compared on every decode.
// RL18: low 1 to 5 address bits form the unit's register offset.
// RL19: base bits below the range size read zero, unwritable.
// RL20: floppy, serial and keyboard bases keep bits 15-11 zero.
// RL21: the parallel base never exceeds 3F8h.
// RL22: other units accept any base up to FFFXh; the code also keeps the mouse base bits 15-11 zero.
// RL23: unimplemented indexes ignore writes, read 00h; DMA reads 04h.
// RL24: interrupt bits 3-0 select line 1-15; bit 4 enables wake.
// RL25: interrupt type bit 0 edge/level, bit 1 low/high polarity.
`timescale 1ns/1ps
`include "pnp_cfg_regs.svh"
module pnp_config_and_address_decode (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic hostResetIn,
    input wire logic standbyUp,
    input wire logic configBaseStrap,
    input wire pnp_cfg_pkg::io_addr_t ioAddr,
    input wire logic [7:0] ioWrData,
    input wire logic ioWrite,
    input wire logic ioRead,
    output logic [7:0] ioRdData,
    output logic ioRdValid,
    output logic [14:0] unitSelect,
    output logic [4:0] unitOffset,
    output logic [14:0] unitActive,
    output logic [59:0] unitIrqLine,
    output logic [14:0] unitIrqWake,
    output logic [14:0] unitIrqLevel,
    output logic [14:0] unitIrqHigh,
    output logic [44:0] unitDmaOne,
    output logic [44:0] unitDmaTwo,
    output logic [1:0] pinSelect,
    output logic cfgLocked
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    function automatic pnp_cfg_pkg::unit_t asUnit(input logic [3:0] u);
        return pnp_cfg_pkg::unit_t'(u);
    endfunction

    // range size per unit as a count of offset bits
    function automatic logic [2:0] alignOf(input logic [3:0] u);
        unique case (asUnit(u))
            pnp_cfg_pkg::UNIT_KBD, pnp_cfg_pkg::UNIT_MOUSE,
            pnp_cfg_pkg::UNIT_TIMER, pnp_cfg_pkg::UNIT_MIDI: return 3'h1;
            pnp_cfg_pkg::UNIT_WAKE, pnp_cfg_pkg::UNIT_GPIO,
            pnp_cfg_pkg::UNIT_FAN, pnp_cfg_pkg::UNIT_TEMP: return 3'h4;
            pnp_cfg_pkg::UNIT_VOLT: return 3'h5;
            default: return 3'h3;
        endcase
    endfunction

    function automatic logic isLegacy(input logic [3:0] u);
        unique case (asUnit(u))
            pnp_cfg_pkg::UNIT_FLOPPY, pnp_cfg_pkg::UNIT_SERIAL2,
            pnp_cfg_pkg::UNIT_SERIAL1, pnp_cfg_pkg::UNIT_KBD,
            pnp_cfg_pkg::UNIT_MOUSE: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    function automatic logic hasBase1(input logic [3:0] u);
        return u == `KBD_UNIT;  // [RL5]
    endfunction

    function automatic logic [1:0] dmaCount(input logic [3:0] u);
        unique case (asUnit(u))
            pnp_cfg_pkg::UNIT_FLOPPY, pnp_cfg_pkg::UNIT_PARALLEL: return 2'h1;
            pnp_cfg_pkg::UNIT_SERIAL2: return 2'h2;
            default: return 2'h0;
        endcase
    endfunction

    // alignment and range limits applied to a merged base value
    function automatic pnp_cfg_pkg::io_addr_t fitBase(input logic [3:0] u,
            input pnp_cfg_pkg::io_addr_t v);
        pnp_cfg_pkg::io_addr_t lim;
        lim = isLegacy(u) ? `LEGACY_BASE_MASK : `FULL_BASE_MASK;  // [RL20] [RL22]
        return v & lim & (16'hFFFF << alignOf(u));  // [RL19]
    endfunction

    function automatic pnp_cfg_pkg::io_addr_t legacyBase(input logic [3:0] u);
        unique case (asUnit(u))
            pnp_cfg_pkg::UNIT_FLOPPY: return `FLOPPY_BASE_RST;
            pnp_cfg_pkg::UNIT_PARALLEL: return `PAR_BASE_RST;
            pnp_cfg_pkg::UNIT_SERIAL2: return `SER2_BASE_RST;
            pnp_cfg_pkg::UNIT_SERIAL1: return `SER1_BASE_RST;
            pnp_cfg_pkg::UNIT_KBD: return `KBD_DATA_RST;
            default: return 16'h0000;
        endcase
    endfunction

    function automatic logic [4:0] legacyIrq(input logic [3:0] u);
        unique case (asUnit(u))
            pnp_cfg_pkg::UNIT_FLOPPY: return `FLOPPY_IRQ_RST;
            pnp_cfg_pkg::UNIT_PARALLEL: return `PAR_IRQ_RST;
            pnp_cfg_pkg::UNIT_SERIAL2: return `SER2_IRQ_RST;
            pnp_cfg_pkg::UNIT_SERIAL1: return `SER1_IRQ_RST;
            pnp_cfg_pkg::UNIT_MOUSE: return `MOUSE_IRQ_RST;
            pnp_cfg_pkg::UNIT_KBD: return `KBD_IRQ_RST;
            default: return 5'h00;
        endcase
    endfunction

    // pins from outside the clock domain
    logic [2:0] pinMeta;
    logic [2:0] pinSync;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pinMeta <= 3'h0;
            pinSync <= 3'h0;
        end else begin
            pinMeta <= {configBaseStrap, standbyUp, hostResetIn};
            pinSync <= pinMeta;
        end
    end
    logic hwRst;
    logic standbyRst;
    assign hwRst = pinSync[0];
    assign standbyRst = pinSync[1];

    // index/data port and global registers
    pnp_cfg_pkg::io_addr_t cfgBase;
    logic [7:0] cfgIndex;
    logic [3:0] unitNum;
    logic [1:0] gcfgThree;
    logic swRst;
    logic idxWr;
    logic datWr;
    logic datRd;
    logic unitWr;
    assign idxWr = ioWrite && ioAddr == cfgBase;  // [RL17]
    assign datWr = ioWrite && ioAddr == cfgBase + 16'h0001;
    assign datRd = ioRead && ioAddr == cfgBase + 16'h0001;
    assign unitWr = datWr && cfgIndex >= `IDX_UNIT_FIRST && unitNum < 4'hF;

    // strap is caught while hardware reset is held, not at the async edge
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfgBase <= `CFG_PORT_LOW;
        end else if (hwRst) begin
            cfgBase <= pinSync[2] ? `CFG_PORT_HIGH : `CFG_PORT_LOW;  // [RL13]
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfgIndex <= 8'h00;
            unitNum <= 4'h0;
        end else if (hwRst || swRst) begin
            cfgIndex <= 8'h00;
            unitNum <= 4'h0;
        end else begin
            if (idxWr) begin
                cfgIndex <= ioWrData;
            end
            if (datWr && cfgIndex == `IDX_UNIT_NUM) begin
                unitNum <= ioWrData[3:0];
            end
        end
    end

    // software reset pulse; the bit reads back as zero
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            swRst <= 1'b0;
        end else begin
            swRst <= datWr && cfgIndex == `IDX_GCFG_ONE && ioWrData[`GC1_SWRST_BIT];  // [RL8]
        end
    end

    // lock only clears on hardware reset; locked pin selects survive soft reset
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfgLocked <= 1'b0;
            gcfgThree <= 2'h0;
        end else if (hwRst) begin
            cfgLocked <= 1'b0;
            gcfgThree <= 2'h0;  // [RL15]
        end else if (swRst) begin
            if (!cfgLocked) begin
                gcfgThree <= 2'h0;  // [RL9]
            end
        end else if (datWr && cfgIndex == `IDX_GCFG_ONE && ioWrData[`GC1_LOCK_BIT]) begin
            cfgLocked <= 1'b1;
        end else if (datWr && cfgIndex == `IDX_GCFG_THREE && !cfgLocked) begin
            gcfgThree <= ioWrData[1:0];
        end
    end
    assign pinSelect = gcfgThree;

    // per-unit storage
    logic [14:0] act;
    pnp_cfg_pkg::io_addr_t base0 [15];
    pnp_cfg_pkg::io_addr_t base1 [15];
    logic [4:0] irqNum [15];
    logic [1:0] irqType [15];
    logic [2:0] dma0 [15];
    logic [2:0] dma1 [15];
    logic [7:0] funcCfg [15];
    logic [14:0] hitNow;

    for (genvar u = 0; u < `NUM_UNITS; u++) begin : g_unit
        localparam logic [3:0] U = 4'(u);
        logic clr;
        logic sel;
        logic hit0;
        logic hit1;
        pnp_cfg_pkg::io_addr_t mergedBase;
        // wake unit ignores hardware reset and follows standby power-up
        assign clr = swRst || (U == `WAKE_UNIT ? standbyRst : hwRst);  // [RL10] [RL12]
        assign sel = unitWr && unitNum == U;
        assign mergedBase = fitBase(U, (cfgIndex[1] ? base1[u] : base0[u]) & ~(cfgIndex[0]
            ? 16'h00FF : 16'hFF00) | (cfgIndex[0] ? {8'h00, ioWrData} : {ioWrData, 8'h00}));

        always_ff @(posedge core_clk or posedge sys_rst) begin
            if (sys_rst) begin
                act[u] <= U == `KBD_UNIT;  // [RL14] [RL11]
                base0[u] <= legacyBase(U);  // [RL16]
                base1[u] <= U == `KBD_UNIT ? `KBD_CMD_RST : 16'h0000;
                irqNum[u] <= legacyIrq(U);
                irqType[u] <= 2'h0;
                dma0[u] <= U == 4'h0 ? `FLOPPY_DMA_RST : `DMA_NONE;  // [RL2]
                dma1[u] <= `DMA_NONE;
            end else if (clr) begin
                act[u] <= U == `KBD_UNIT;  // [RL14]
                base0[u] <= legacyBase(U);  // [RL16]
                base1[u] <= U == `KBD_UNIT ? `KBD_CMD_RST : 16'h0000;
                irqNum[u] <= legacyIrq(U);
                irqType[u] <= 2'h0;
                dma0[u] <= U == 4'h0 ? `FLOPPY_DMA_RST : `DMA_NONE;
                dma1[u] <= `DMA_NONE;
            end else if (sel) begin
                unique case (cfgIndex)
                    `IDX_ACTIVATE: act[u] <= ioWrData[`ACT_ENABLE_BIT];  // [RL3]
                    `IDX_BASE0_HI, `IDX_BASE0_LO: begin
                        // parallel writes that would pass the limit are dropped
                        if (U != 4'h1 || mergedBase <= `PAR_BASE_MAX) begin  // [RL21]
                            base0[u] <= mergedBase;  // [RL4]
                        end
                    end
                    `IDX_BASE1_HI, `IDX_BASE1_LO: begin
                        if (hasBase1(U)) begin
                            base1[u] <= mergedBase;  // [RL5]
                        end
                    end
                    `IDX_IRQ_NUM: irqNum[u] <= ioWrData[4:0];  // [RL6] [RL24]
                    `IDX_IRQ_TYPE: irqType[u] <= ioWrData[1:0];  // [RL25]
                    `IDX_DMA_FIRST: begin
                        if (dmaCount(U) != 2'h0) begin
                            dma0[u] <= ioWrData[2:0];  // [RL1]
                        end
                    end
                    `IDX_DMA_SECOND: begin
                        if (dmaCount(U) == 2'h2) begin
                            dma1[u] <= ioWrData[2:0];  // [RL1]
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end

        // only the wake unit's function-specific byte is held by the retention supply
        always_ff @(posedge core_clk or posedge sys_rst) begin
            if (sys_rst) begin
                funcCfg[u] <= 8'h00;  // [RL11]
            end else if (clr && U != `WAKE_UNIT) begin
                funcCfg[u] <= 8'h00;
            end else if (sel && cfgIndex == `IDX_FUNC_CFG) begin
                funcCfg[u] <= ioWrData;  // [RL7]
            end
        end

        // a zero base means no resource is assigned
        pnp_base_decode u_dec0 (
            .reqAddr(ioAddr),
            .base(base0[u]),
            .alignBits(alignOf(U)),
            .enable(act[u] && base0[u] != 16'h0000),
            .hit(hit0)
        );
        pnp_base_decode u_dec1 (
            .reqAddr(ioAddr),
            .base(base1[u]),
            .alignBits(3'h0),
            .enable(act[u] && hasBase1(U) && base1[u] != 16'h0000),
            .hit(hit1)
        );
        assign hitNow[u] = hit0 || hit1;  // [RL17] [RL3]

        assign unitActive[u] = act[u];
        assign unitIrqLine[4*u +: 4] = irqNum[u][3:0];
        assign unitIrqWake[u] = irqNum[u][`IRQ_WAKE_BIT];
        assign unitIrqLevel[u] = irqType[u][0];
        assign unitIrqHigh[u] = irqType[u][1];
        assign unitDmaOne[3*u +: 3] = dma0[u];
        assign unitDmaTwo[3*u +: 3] = dma1[u];

        chk_base_align: assert property (  // [RL19]
            (base0[u] & ~(16'hFFFF << alignOf(U))) == 16'h0000)
            else $error("base below range size not zero");
        if (u == 0 || u == 2 || u == 3 || u == 6) begin : g_leg
            chk_legacy_limit: assert property (base0[u][15:11] == 5'h00)  // [RL20]
                else $error("legacy base above 7FFh");
        end
    end

    // unit selects and offset, one cycle after the request
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            unitSelect <= 15'h0000;
            unitOffset <= 5'h00;
        end else begin
            unitSelect <= (ioRead || ioWrite) ? hitNow : 15'h0000;
            unitOffset <= ioAddr[4:0];  // [RL18]
        end
    end

    // configuration read data
    logic [7:0] rdByte;
    logic [3:0] rdUnit;
    always_comb begin
        rdUnit = unitNum < 4'hF ? unitNum : 4'h0;
        rdByte = `RD_UNIMPL;
        if (ioAddr == cfgBase) begin
            rdByte = cfgIndex;
        end else if (cfgIndex == `IDX_UNIT_NUM) begin
            rdByte = {4'h0, unitNum};
        end else if (cfgIndex == `IDX_CHIP_ID) begin
            rdByte = `CHIP_ID_VALUE;
        end else if (cfgIndex == `IDX_GCFG_ONE) begin
            rdByte = {cfgLocked, 7'h00};
        end else if (cfgIndex == `IDX_GCFG_THREE) begin
            rdByte = {6'h00, gcfgThree};
        end else if (cfgIndex == `IDX_DMA_FIRST || cfgIndex == `IDX_DMA_SECOND) begin
            rdByte = `RD_UNIMPL_DMA;  // [RL23]
            if (unitNum < 4'hF && cfgIndex == `IDX_DMA_FIRST && dmaCount(rdUnit) != 2'h0) begin
                rdByte = {5'h00, dma0[rdUnit]};
            end else if (unitNum < 4'hF && dmaCount(rdUnit) == 2'h2) begin
                rdByte = {5'h00, dma1[rdUnit]};
            end
        end else if (unitNum < 4'hF) begin
            unique case (cfgIndex)
                `IDX_ACTIVATE: rdByte = {7'h00, act[rdUnit]};
                `IDX_BASE0_HI: rdByte = base0[rdUnit][15:8];
                `IDX_BASE0_LO: rdByte = base0[rdUnit][7:0];
                `IDX_BASE1_HI: rdByte = hasBase1(rdUnit) ? base1[rdUnit][15:8] : `RD_UNIMPL;
                `IDX_BASE1_LO: rdByte = hasBase1(rdUnit) ? base1[rdUnit][7:0] : `RD_UNIMPL;
                `IDX_IRQ_NUM: rdByte = {3'h0, irqNum[rdUnit]};
                `IDX_IRQ_TYPE: rdByte = {6'h00, irqType[rdUnit]};
                `IDX_FUNC_CFG: rdByte = funcCfg[rdUnit];
                default: rdByte = `RD_UNIMPL;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ioRdData <= 8'h00;
            ioRdValid <= 1'b0;
        end else begin
            ioRdValid <= ioRead && (ioAddr == cfgBase || datRd);
            ioRdData <= rdByte;
        end
    end

    sequence selDmaLessUnit;
        datRd && cfgIndex == `IDX_DMA_SECOND && unitNum < 4'hF && dmaCount(unitNum) != 2'h2;
    endsequence
    chk_dma_unimpl: assert property (selDmaLessUnit |=> ioRdData == `RD_UNIMPL_DMA)  // [RL23]
        else $error("missing DMA select did not read 04h");
    chk_sw_reset_act: assert property (swRst && !hwRst |=> unitActive[6] && !unitActive[0])  // [RL14]
        else $error("soft reset left wrong units active");
    chk_lock_holds: assert property (swRst && cfgLocked && !hwRst |=> $stable(pinSelect))  // [RL9]
        else $error("locked pin select changed by soft reset");
    chk_wake_kept: assert property (hwRst && !swRst && !standbyRst && !unitWr |=> $stable(act[4]))  // [RL10]
        else $error("hardware reset touched the wake unit");
    chk_par_limit: assert property (base0[1] <= `PAR_BASE_MAX)  // [RL21]
        else $error("parallel base above 3F8h");
    chk_port_base: assert property (hwRst ##1 hwRst |-> cfgBase == (pinSync[2] ? `CFG_PORT_HIGH  // [RL13]
        : `CFG_PORT_LOW) || $changed(pinSync[2]))
        else $error("config port base does not follow strap");
    chk_select_hit: assert property (ioRead && hitNow[6] |=> unitSelect[6]  // [RL17]
        && unitOffset == $past(ioAddr[4:0]))
        else $error("decoded access missed its unit select");
    chk_swrst_pulse: assert property (datWr && cfgIndex == `IDX_GCFG_ONE && ioWrData[1]  // [RL8]
        |=> swRst ##1 !swRst)
        else $error("soft reset did not pulse");
endmodule

// file: bench/host_cfg_master.sv
// host bus controller model issuing single-cycle I/O read and write strobes
`timescale 1ns/1ps
module host_cfg_master (
    input wire logic core_clk,
    output pnp_cfg_pkg::io_addr_t ioAddr,
    output logic [7:0] ioWrData,
    output logic ioWrite,
    output logic ioRead
);
    initial begin
        ioAddr = 16'h0000;
        ioWrData = 8'h00;
        ioWrite = 1'b0;
        ioRead = 1'b0;
    end

    task automatic access(input pnp_cfg_pkg::io_addr_t a, input logic [7:0] d, input logic w);
        @(negedge core_clk);
        ioAddr = a;
        ioWrData = d;
        ioWrite = w;
        ioRead = !w;
        @(negedge core_clk);
        ioWrite = 1'b0;
        ioRead = 1'b0;
        // scramble between strobes so nothing leans on a stale address or byte
        ioAddr = ~a;
        ioWrData = ~d;
    endtask
endmodule

// file: bench/pnp_config_and_address_decode_bench.sv
// self-checking bench for the configuration register file and unit decode
`timescale 1ns/1ps
module pnp_config_and_address_decode_bench;
    logic core_clk, sys_rst, hostResetIn, configBaseStrap, ioWrite, ioRead, ioRdValid, cfgLocked;
    logic standbyUp;
    pnp_cfg_pkg::io_addr_t ioAddr;
    pnp_cfg_pkg::io_addr_t port = 16'h002E;
    logic [7:0] ioWrData, ioRdData, f;
    logic [14:0] unitSelect, unitActive, unitIrqWake, unitIrqLevel, unitIrqHigh;
    logic [4:0] unitOffset;
    logic [59:0] unitIrqLine;
    logic [44:0] unitDmaOne, unitDmaTwo;
    logic [1:0] pinSelect, t;
    logic [3:0] q;
    logic w;
    logic [7:0] expQ[$];
    int errorCnt = 0;
    int comparisons = 0;

    pnp_config_and_address_decode i_pnp_config_and_address_decode (.core_clk(core_clk),
        .sys_rst(sys_rst), .hostResetIn(hostResetIn), .standbyUp(standbyUp),
        .configBaseStrap(configBaseStrap), .ioAddr(ioAddr), .ioWrData(ioWrData),
        .ioWrite(ioWrite), .ioRead(ioRead), .ioRdData(ioRdData), .ioRdValid(ioRdValid),
        .unitSelect(unitSelect), .unitOffset(unitOffset), .unitActive(unitActive),
        .unitIrqLine(unitIrqLine), .unitIrqWake(unitIrqWake), .unitIrqLevel(unitIrqLevel),
        .unitIrqHigh(unitIrqHigh), .unitDmaOne(unitDmaOne), .unitDmaTwo(unitDmaTwo),
        .pinSelect(pinSelect), .cfgLocked(cfgLocked));
    host_cfg_master i_host_cfg_master (.core_clk(core_clk), .ioAddr(ioAddr),
        .ioWrData(ioWrData), .ioWrite(ioWrite), .ioRead(ioRead));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errorCnt++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cfgWr(input logic [7:0] idx, input logic [7:0] d);
        i_host_cfg_master.access(port, idx, 1'b1);
        i_host_cfg_master.access(port + 16'h0001, d, 1'b1);
    endtask
    // expectation is queued before the strobe so the watcher always finds it
    task automatic cfgRd(input logic [7:0] idx, input logic [7:0] exp);
        i_host_cfg_master.access(port, idx, 1'b1);
        expQ.push_back(exp);
        i_host_cfg_master.access(port + 16'h0001, 8'h00, 1'b0);
    endtask
    task automatic hit(input logic [15:0] a, input logic [14:0] exp);
        i_host_cfg_master.access(a, 8'h00, 1'b0);
        check({1'b0, unitSelect}, {1'b0, exp});
        check({11'h000, unitOffset}, {11'h000, a[4:0]});
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, errorCnt);
        if (errorCnt == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    always @(negedge core_clk) begin
        if (ioRdValid === 1'b1) begin
            if (expQ.size() == 0) begin
                check(16'h0001, 16'h0000);
            end else begin
                check({8'h00, ioRdData}, {8'h00, expQ.pop_front()});
            end
        end
    end

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        #100000;
        errorCnt++;
        conclude();
    end

    initial begin
        sys_rst = 1'b1;
        hostResetIn = 1'b0;
        standbyUp = 1'b0;
        configBaseStrap = 1'b0;
        void'($urandom(12578));
        repeat (2) @(negedge core_clk);
        sys_rst = 1'b0;
        cfgWr(8'h07, 8'h06);
        cfgRd(8'h30, 8'h01);
        cfgRd(8'h61, 8'h60);
        cfgRd(8'h63, 8'h64);
        hit(16'h0061, 15'h0040);
        hit(16'h1060, 15'h0000);
        cfgWr(8'h07, 8'h00);
        cfgRd(8'h74, 8'h02);
        cfgRd(8'h75, 8'h04);
        cfgRd(8'h31, 8'h00);
        cfgWr(8'h07, 8'h02);
        // the host never programs the reserved codes 5-7
        for (int i = 0; i < 5; i++) begin
            cfgWr(8'h74, 8'(i));
            cfgWr(8'h75, 8'(4 - i));
            check({13'h0000, unitDmaOne[8:6]}, 16'(i));
            check({13'h0000, unitDmaTwo[8:6]}, 16'(4 - i));
        end
        cfgWr(8'h07, 8'h03);
        cfgWr(8'h61, 8'hFF);
        cfgRd(8'h61, 8'hF8);
        cfgWr(8'h60, 8'hFF);
        cfgRd(8'h60, 8'h07);
        q = 4'($urandom_range(1, 15));
        w = 1'($urandom);
        t = 2'($urandom);
        cfgWr(8'h70, {3'h0, w, q});
        cfgWr(8'h71, {6'h00, t});
        cfgRd(8'h70, {3'h0, w, q});
        check({11'h000, unitIrqWake[3], unitIrqLine[15:12]}, {11'h000, w, q});
        check({14'h0000, unitIrqHigh[3], unitIrqLevel[3]}, {14'h0000, t});
        cfgWr(8'h07, 8'h01);
        cfgWr(8'h60, 8'h04);
        cfgRd(8'h60, 8'h02);
        cfgWr(8'h07, 8'h0B);
        cfgWr(8'h60, 8'hFF);
        cfgWr(8'h61, 8'hFF);
        hit(16'hFFFA, 15'h0000);
        cfgWr(8'h30, 8'h01);
        hit(16'hFFFA, 15'h0800);
        f = 8'($urandom);
        cfgWr(8'hF0, f);
        cfgRd(8'hF0, f);
        cfgWr(8'h23, 8'h03);
        check({14'h0000, pinSelect}, 16'h0003);
        cfgWr(8'h21, 8'h80);
        cfgWr(8'h23, 8'h01);
        check({15'h0000, cfgLocked}, 16'h0001);
        cfgRd(8'h23, 8'h03);
        cfgWr(8'h21, 8'h02);
        repeat (3) @(negedge core_clk);
        check({1'b0, unitActive}, 16'h0040);
        check({14'h0000, pinSelect}, 16'h0003);
        cfgRd(8'h21, 8'h80);
        hit(16'hFFFA, 15'h0000);
        cfgWr(8'h07, 8'h03);
        cfgRd(8'h60, 8'h03);
        cfgWr(8'h07, 8'h0B);
        cfgWr(8'h30, 8'h01);
        // wake unit active with a retained byte; both must ride out the host reset
        cfgWr(8'h07, 8'h04);
        cfgWr(8'h30, 8'h01);
        cfgWr(8'hF0, f);
        configBaseStrap = 1'b1;
        hostResetIn = 1'b1;
        repeat (6) @(negedge core_clk);
        hostResetIn = 1'b0;
        repeat (4) @(negedge core_clk);
        check({1'b0, unitActive}, 16'h0050);
        check({13'h0000, cfgLocked, pinSelect}, 16'h0000);
        port = 16'h004E;
        cfgWr(8'h07, 8'h06);
        cfgRd(8'h30, 8'h01);
        standbyUp = 1'b1;
        repeat (6) @(negedge core_clk);
        standbyUp = 1'b0;
        repeat (4) @(negedge core_clk);
        check({1'b0, unitActive}, 16'h0040);
        cfgWr(8'h07, 8'h04);
        cfgRd(8'hF0, f);
        repeat (3) @(negedge core_clk);
        check(16'(expQ.size()), 16'h0000);
        conclude();
    end
endmodule
